// [hdl/hmc_regs.sv]
// host mac fifo status, drop counter and indirect csr access register block
`timescale 1ns/10ps
module hmc_regs
(
    input wire logic clk,
    input wire logic rst,
    input wire hmc_pkg::hmc_bus_s bus,
    output logic [31:0] rdata,
    input wire hmc_pkg::hmc_levels_s levels,
    output logic skip_req,
    input wire logic skip_done,
    input wire logic frame_dropped,
    output hmc_pkg::hmc_csr_req_s csr_req,
    input wire logic csr_done,
    input wire logic [31:0] csr_rdata,
    output logic irq
);
    logic skip_r;
    logic [31:0] drop_r;
    logic active_r;
    logic dir_r;
    logic [7:0] index_r;
    logic [31:0] wdata_r;
    logic [31:0] mac_data_r;
    logic [31:0] irq_status_r;
    logic [31:0] irq_mask_r;
    logic [31:0] rdata_r;
    hmc_pkg::hmc_csr_e csr_state;

    wire wr_skip = bus.wr && bus.addr == hmc_pkg::OFF_RX_DISCARD;
    wire wr_cmd = bus.wr && bus.addr == hmc_pkg::OFF_IND_CMD;
    wire wr_data = bus.wr && bus.addr == hmc_pkg::OFF_IND_DATA;
    wire wr_irq_st = bus.wr && bus.addr == hmc_pkg::OFF_IRQ_STATUS;
    wire wr_irq_mask = bus.wr && bus.addr == hmc_pkg::OFF_IRQ_MASK;
    wire rd_drop = bus.rd && bus.addr == hmc_pkg::OFF_DROP_COUNT;
    // a command write is ignored while one runs, so index and direction stay stable
    wire cmd_start = wr_cmd && bus.wdata[hmc_pkg::ACTIVE_BIT] && !active_r;
    wire drop_half = frame_dropped && drop_r == hmc_pkg::DROP_HALF_FROM;
    wire [31:0] irq_set = {8'h00, drop_half, 23'h000000};
    wire [31:0] irq_clr = wr_irq_st ? (bus.wdata & hmc_pkg::IRQ_IMPL_MASK) : 32'h00000000;
    // the halfway step needs 2^31 drops, so in a run only the assertions watch it
    wire half_flag = irq_status_r[hmc_pkg::DROP_HALF_BIT];
    wire half_mask = irq_mask_r[hmc_pkg::DROP_HALF_BIT];
    wire half_clr = wr_irq_st && bus.wdata[hmc_pkg::DROP_HALF_BIT];
    wire skip_set = wr_skip && bus.wdata[hmc_pkg::SKIP_BIT];
    wire rd_skip = bus.rd && bus.addr == hmc_pkg::OFF_RX_DISCARD;
    wire rd_rx_levels = bus.rd && bus.addr == hmc_pkg::OFF_RX_LEVELS;
    wire rd_tx_levels = bus.rd && bus.addr == hmc_pkg::OFF_TX_LEVELS;
    wire rd_cmd = bus.rd && bus.addr == hmc_pkg::OFF_IND_CMD;
    wire rd_data = bus.rd && bus.addr == hmc_pkg::OFF_IND_DATA;
    wire rd_irq_st = bus.rd && bus.addr == hmc_pkg::OFF_IRQ_STATUS;
    wire addr_mapped = bus.addr inside {hmc_pkg::OFF_RX_DISCARD, hmc_pkg::OFF_RX_LEVELS,
        hmc_pkg::OFF_TX_LEVELS, hmc_pkg::OFF_DROP_COUNT, hmc_pkg::OFF_IND_CMD,
        hmc_pkg::OFF_IND_DATA, hmc_pkg::OFF_IRQ_STATUS, hmc_pkg::OFF_IRQ_MASK};

    // held until core reports done
    // a write in the done cycle wins: the host has asked for one more skip
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            skip_r <= 1'b0;
        else if (skip_set)
            skip_r <= 1'b1;
        else if (skip_r && skip_done)
            skip_r <= 1'b0;
    end
    assign skip_req = skip_r;

    // clear on read; a drop in the read cycle is kept as count one
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            drop_r <= hmc_pkg::DROP_RESET;
        else if (rd_drop)
            drop_r <= frame_dropped ? 32'h00000001 : 32'h00000000;
        else if (frame_dropped)
            drop_r <= drop_r + 32'h00000001;
    end

    // sticky half flag, set wins over write-one clear
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_status_r <= hmc_pkg::IRQ_RESET;
        else
            irq_status_r <= (irq_status_r & ~irq_clr) | irq_set;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            irq_mask_r <= hmc_pkg::IRQ_RESET;
        else if (wr_irq_mask)
            irq_mask_r <= bus.wdata & hmc_pkg::IRQ_IMPL_MASK;
    end
    assign irq = |(irq_status_r & irq_mask_r);

    // index and direction held from the command write
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dir_r <= 1'b0;
            index_r <= hmc_pkg::INDEX_RESET;
        end
        else if (wr_cmd && !active_r)
        begin
            dir_r <= bus.wdata[hmc_pkg::DIR_BIT];
            index_r <= bus.wdata[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            wdata_r <= hmc_pkg::DATA_RESET;
        else if (wr_data && !active_r)
            wdata_r <= bus.wdata;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            csr_state <= hmc_pkg::CSR_IDLE;
            active_r <= 1'b0;
            mac_data_r <= hmc_pkg::DATA_RESET;
        end
        else
        begin
            unique case (csr_state)
                hmc_pkg::CSR_IDLE:
                begin
                    if (cmd_start)
                    begin
                        csr_state <= hmc_pkg::CSR_WAIT;
                        active_r <= 1'b1;
                    end
                end
                hmc_pkg::CSR_WAIT:
                begin
                    if (csr_done)
                    begin
                        csr_state <= hmc_pkg::CSR_IDLE;
                        active_r <= 1'b0;
                        if (dir_r)
                            mac_data_r <= csr_rdata;
                    end
                end
                default:
                    csr_state <= hmc_pkg::CSR_IDLE;
            endcase
        end
    end

    // direction and payload toward the mac
    assign csr_req = '{req: active_r, read: dir_r, index: index_r, wdata: wdata_r};

    wire [31:0] rx_levels = {8'h00, levels.rx_status_fill, levels.rx_data_fill};
    wire [31:0] tx_levels = {8'h00, levels.tx_status_fill, levels.tx_data_room};
    wire [31:0] cmd_view = {active_r, dir_r, 22'h000000, index_r};
    wire [31:0] data_view = dir_r ? mac_data_r : wdata_r;
    wire [31:0] read_mux =
        bus.addr == hmc_pkg::OFF_RX_DISCARD ? {skip_r, 31'h00000000} :
        bus.addr == hmc_pkg::OFF_RX_LEVELS ? rx_levels :
        bus.addr == hmc_pkg::OFF_TX_LEVELS ? tx_levels :
        bus.addr == hmc_pkg::OFF_DROP_COUNT ? drop_r :
        bus.addr == hmc_pkg::OFF_IND_CMD ? cmd_view :
        bus.addr == hmc_pkg::OFF_IND_DATA ? data_view :
        bus.addr == hmc_pkg::OFF_IRQ_STATUS ? irq_status_r :
        bus.addr == hmc_pkg::OFF_IRQ_MASK ? irq_mask_r : 32'h00000000;

    // read data valid only the cycle after the strobe; zero otherwise
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            rdata_r <= hmc_pkg::DATA_RESET;
        else
            rdata_r <= bus.rd ? read_mux : 32'h00000000;
    end
    assign rdata = rdata_r;

    a_drop_read_clear: assert property (@(posedge clk) disable iff (rst)
        rd_drop && !frame_dropped |=> rdata == $past(drop_r) && drop_r == 32'h00000000)
        else $error("drop counter read did not return and clear");

    a_drop_count_up: assert property (@(posedge clk) disable iff (rst)
        frame_dropped && !rd_drop |=> drop_r == $past(drop_r) + 32'h00000001)
        else $error("drop counter did not increment");

    a_drop_half_flag: assert property (@(posedge clk) disable iff (rst)
        drop_half |=> irq_status_r[hmc_pkg::DROP_HALF_BIT])
        else $error("halfway flag not set");

    sequence s_cmd_go;
        cmd_start ##1 active_r;
    endsequence
    a_cmd_start: assert property (@(posedge clk) disable iff (rst)
        cmd_start |-> s_cmd_go)
        else $error("command start not taken");

    a_cmd_hold: assert property (@(posedge clk) disable iff (rst)
        active_r && !csr_done |=> active_r)
        else $error("active bit dropped before completion");

    a_read_data: assert property (@(posedge clk) disable iff (rst)
        active_r && csr_done && dir_r |=> mac_data_r == $past(csr_rdata) && !active_r)
        else $error("read data not captured");

    a_skip_hold: assert property (@(posedge clk) disable iff (rst)
        skip_r && !skip_done |=> skip_r)
        else $error("skip bit cleared early");

    a_skip_start: assert property (@(posedge clk) disable iff (rst)
        wr_skip && bus.wdata[hmc_pkg::SKIP_BIT] |=> skip_req)
        else $error("skip request not raised");

    a_index_reset: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> index_r == hmc_pkg::INDEX_RESET)
        else $error("index not at reset value");

    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        bus.rd && bus.addr == hmc_pkg::OFF_IND_CMD |=> rdata[29:8] == 22'h000000)
        else $error("reserved command bits not zero");

    a_tx_levels: assert property (@(posedge clk) disable iff (rst)
        bus.rd && bus.addr == hmc_pkg::OFF_TX_LEVELS |=> rdata[15:0] == $past(levels.tx_data_room))
        else $error("tx room field wrong");

    sequence s_skip_end;
        skip_r && skip_done ##1 !skip_r;
    endsequence
    a_skip_end: assert property (@(posedge clk) disable iff (rst)
        skip_r && skip_done && !skip_set |-> s_skip_end)
        else $error("skip bit not cleared on done");

    a_skip_quiet: assert property (@(posedge clk) disable iff (rst)
        !skip_r && !skip_set |=> !skip_r)
        else $error("skip bit rose without a write");

    a_skip_view: assert property (@(posedge clk) disable iff (rst)
        rd_skip |=> rdata == {$past(skip_r), 31'h00000000})
        else $error("skip bit read wrong");

    a_rx_status_fill: assert property (@(posedge clk) disable iff (rst)
        rd_rx_levels |=> rdata[23:16] == $past(levels.rx_status_fill))
        else $error("rx status fill field wrong");

    a_rx_data_fill: assert property (@(posedge clk) disable iff (rst)
        rd_rx_levels |=> rdata[15:0] == $past(levels.rx_data_fill))
        else $error("rx data fill field wrong");

    a_tx_status_fill: assert property (@(posedge clk) disable iff (rst)
        rd_tx_levels |=> rdata[23:16] == $past(levels.tx_status_fill))
        else $error("tx status fill field wrong");

    a_levels_reserved: assert property (@(posedge clk) disable iff (rst)
        rd_rx_levels || rd_tx_levels |=> rdata[31:24] == 8'h00)
        else $error("level reserved bits not zero");

    a_drop_steady: assert property (@(posedge clk) disable iff (rst)
        !frame_dropped && !rd_drop |=> $stable(drop_r))
        else $error("drop counter moved without a drop");

    a_drop_read_race: assert property (@(posedge clk) disable iff (rst)
        rd_drop && frame_dropped |=> drop_r == 32'h00000001 && rdata == $past(drop_r))
        else $error("drop in read cycle lost");

    a_half_quiet: assert property (@(posedge clk) disable iff (rst)
        !half_flag && !drop_half |=> !half_flag)
        else $error("halfway flag set without the step");

    a_half_sticky: assert property (@(posedge clk) disable iff (rst)
        half_flag && !half_clr |=> half_flag)
        else $error("halfway flag lost without a clear");

    a_half_clear: assert property (@(posedge clk) disable iff (rst)
        half_flag && half_clr && !drop_half |=> !half_flag)
        else $error("halfway flag not cleared by write");

    a_irq_out: assert property (@(posedge clk) disable iff (rst)
        half_flag && half_mask |-> irq)
        else $error("interrupt missing for unmasked flag");

    a_irq_masked: assert property (@(posedge clk) disable iff (rst)
        !half_mask |-> !irq)
        else $error("interrupt raised while masked");

    a_status_reserved: assert property (@(posedge clk) disable iff (rst)
        rd_irq_st |=> (rdata & ~hmc_pkg::IRQ_IMPL_MASK) == 32'h00000000)
        else $error("status reserved bits not zero");

    a_cmd_idle: assert property (@(posedge clk) disable iff (rst)
        !active_r && !cmd_start |=> !active_r)
        else $error("active bit rose without a command");

    a_req_launch: assert property (@(posedge clk) disable iff (rst)
        cmd_start |=> csr_req.req && csr_req.index == $past(bus.wdata[7:0])
            && csr_req.read == $past(bus.wdata[hmc_pkg::DIR_BIT]))
        else $error("request does not carry the command");

    sequence s_csr_end;
        active_r && csr_done ##1 !active_r;
    endsequence
    a_csr_end: assert property (@(posedge clk) disable iff (rst)
        active_r && csr_done |-> s_csr_end)
        else $error("active bit not cleared on completion");

    a_cmd_locked: assert property (@(posedge clk) disable iff (rst)
        active_r |=> $stable(index_r) && $stable(dir_r))
        else $error("command changed while active");

    a_cmd_view: assert property (@(posedge clk) disable iff (rst)
        rd_cmd |=> rdata[31] == $past(active_r) && rdata[30] == $past(dir_r)
            && rdata[7:0] == $past(index_r))
        else $error("command read wrong");

    a_dir_take: assert property (@(posedge clk) disable iff (rst)
        wr_cmd && !active_r |=> dir_r == $past(bus.wdata[hmc_pkg::DIR_BIT]))
        else $error("direction not taken");

    a_req_write_data: assert property (@(posedge clk) disable iff (rst)
        cmd_start && !bus.wdata[hmc_pkg::DIR_BIT] |=> csr_req.wdata == $past(wdata_r))
        else $error("write payload wrong");

    a_mac_data_keep: assert property (@(posedge clk) disable iff (rst)
        !(active_r && csr_done && dir_r) |=> $stable(mac_data_r))
        else $error("mac data changed outside a read");

    a_index_take: assert property (@(posedge clk) disable iff (rst)
        wr_cmd && !active_r |=> index_r == $past(bus.wdata[7:0]))
        else $error("index not taken");

    a_data_take: assert property (@(posedge clk) disable iff (rst)
        wr_data && !active_r |=> wdata_r == $past(bus.wdata))
        else $error("data write not taken");

    a_data_locked: assert property (@(posedge clk) disable iff (rst)
        active_r |=> $stable(wdata_r))
        else $error("data changed while active");

    a_data_view: assert property (@(posedge clk) disable iff (rst)
        rd_data |=> rdata == ($past(dir_r) ? $past(mac_data_r) : $past(wdata_r)))
        else $error("data register read wrong");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
        bus.rd && !addr_mapped |=> rdata == 32'h00000000)
        else $error("unmapped read not zero");
endmodule

// [shared/hmc_pkg.sv]
// package: register map, field layout and shared types of the host mac fifo/csr register block
package hmc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_RX_DISCARD = 8'h78;
    localparam logic [7:0] OFF_RX_LEVELS = 8'h7c;
    localparam logic [7:0] OFF_TX_LEVELS = 8'h80;
    localparam logic [7:0] OFF_DROP_COUNT = 8'ha0;
    localparam logic [7:0] OFF_IND_CMD = 8'ha4;
    localparam logic [7:0] OFF_IND_DATA = 8'ha8;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'hb0;
    localparam logic [7:0] OFF_IRQ_MASK = 8'hb4;
    localparam int SKIP_BIT = 31;
    localparam int ACTIVE_BIT = 31;
    localparam int DIR_BIT = 30;
    localparam int DROP_HALF_BIT = 23;
    localparam logic [15:0] TX_ROOM_RESET = 16'h1200;
    localparam logic [31:0] DROP_HALF_FROM = 32'h7fffffff;
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [31:0] DROP_RESET = 32'h00000000;
    localparam logic [31:0] DATA_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_RESET = 32'h00000000;
    localparam logic [31:0] IRQ_IMPL_MASK = 32'h00800000;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hmc_bus_s;

    // fifo fill information from the mac core
    typedef struct packed {
        logic [7:0] rx_status_fill;
        logic [15:0] rx_data_fill;
        logic [7:0] tx_status_fill;
        logic [15:0] tx_data_room;
    } hmc_levels_s;

    // indirect access request towards the mac csr space
    typedef struct packed {
        logic req;
        logic read;
        logic [7:0] index;
        logic [31:0] wdata;
    } hmc_csr_req_s;

    typedef enum logic [1:0] {
        CSR_IDLE,
        CSR_WAIT
    } hmc_csr_e;
endpackage

// [tb/hmc_core_model.sv]
// mac core model: fifo levels, frame skip and indirect csr space
`timescale 1ns/10ps
module hmc_core_model
(
    input wire logic clk,
    input wire logic rst,
    input wire logic skip_req,
    output logic skip_done,
    input wire hmc_pkg::hmc_csr_req_s csr_req,
    output logic csr_done,
    output logic [31:0] csr_rdata,
    output hmc_pkg::hmc_levels_s levels
);
    logic [31:0] mem_r [256];
    logic [2:0] cnt_r;
    logic busy;

    // fixed fill levels, dword rounded data fill
    // no tx data is pushed here, so the room never falls below what is shown
    assign levels = {8'h03, 16'h0044, 8'h02, 16'h1200};
    assign busy = (skip_req && !skip_done) || (csr_req.req && !csr_done);

    // slow answer so the busy phase is visible to the host
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= 3'h0;
            skip_done <= 1'b0;
            csr_done <= 1'b0;
            csr_rdata <= 32'h0;
        end
        else
        begin
            skip_done <= 1'b0;
            csr_done <= 1'b0;
            // read data is only held with the done pulse
            csr_rdata <= ~csr_rdata;
            cnt_r <= busy ? cnt_r + 3'h1 : 3'h0;
            if (cnt_r == 3'h4)
            begin
                skip_done <= skip_req;
                csr_done <= csr_req.req;
                // direction and index pick the access
                if (csr_req.req && csr_req.read)
                    csr_rdata <= mem_r[csr_req.index];
                if (csr_req.req && !csr_req.read)
                    mem_r[csr_req.index] <= csr_req.wdata;
            end
        end
    end
endmodule

// [tb/testbench.sv]
// testbench: host register sequences against the fifo status and indirect csr block
`timescale 1ns/10ps
module testbench;
    logic clk;
    logic rst;
    hmc_pkg::hmc_bus_s bus;
    logic [31:0] rdata;
    hmc_pkg::hmc_levels_s levels;
    logic skip_req;
    logic skip_done;
    logic frame_dropped;
    hmc_pkg::hmc_csr_req_s csr_req;
    logic csr_done;
    logic [31:0] csr_rdata;
    logic irq;
    int error_cnt;
    int compares;

    hmc_regs dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .levels(levels),
        .skip_req(skip_req), .skip_done(skip_done), .frame_dropped(frame_dropped),
        .csr_req(csr_req), .csr_done(csr_done), .csr_rdata(csr_rdata), .irq(irq));
    hmc_core_model core (.clk(clk), .rst(rst), .skip_req(skip_req), .skip_done(skip_done),
        .csr_req(csr_req), .csr_done(csr_done), .csr_rdata(csr_rdata), .levels(levels));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus <= '0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus <= '0;
        #1;
        chk($sformatf("read %h", a), exp, rdata);
    endtask

    // bounded wait for skip and indirect access to finish
    task automatic settle;
        repeat (20)
            if (skip_req || csr_req.req)
                @(posedge clk);
        #1;
        chk("settle busy", 32'h0, {31'h0, skip_req || csr_req.req});
    endtask

    task automatic tally_and_finish;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial
    begin
        #100us;
        chk("watchdog", 32'h0, 32'h1);
        tally_and_finish();
    end

    initial
    begin
        rst = 1'b1;
        bus = '0;
        frame_dropped = 1'b0;
        error_cnt = 0;
        compares = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        rd(8'h7c, 32'h00030044);
        rd(8'h80, 32'h00021200);
        wr(8'h80, 32'hffffffff);
        rd(8'h80, 32'h00021200);
        wr(8'h90, 32'hffffffff);
        rd(8'h90, 32'h0);
        rd(8'hb0, 32'h0);
        wr(8'hb4, 32'hffffffff);
        rd(8'hb4, 32'h00800000);
        chk("irq", 32'h0, {31'h0, irq});
        wr(8'h78, 32'hffffffff);
        chk("skip_req", 32'h1, {31'h0, skip_req});
        rd(8'h78, 32'h80000000);
        // nothing touches the rx data path until the skip bit has dropped
        settle();
        rd(8'h78, 32'h0);
        repeat (3)
        begin
            @(posedge clk);
            frame_dropped <= 1'b1;
            @(posedge clk);
            frame_dropped <= 1'b0;
        end
        // a drop in the read cycle must survive the clear
        fork
            rd(8'ha0, 32'h3);
            begin
                @(posedge clk);
                frame_dropped <= 1'b1;
                @(posedge clk);
                frame_dropped <= 1'b0;
            end
        join
        rd(8'ha0, 32'h1);
        rd(8'ha0, 32'h0);
        wr(8'ha8, 32'h11112222);
        wr(8'ha4, 32'h80000012);
        chk("csr_req", 32'h212, {22'h0, csr_req.req, csr_req.read, csr_req.index});
        chk("csr_wdata", 32'h11112222, csr_req.wdata);
        rd(8'ha4, 32'h80000012);
        wr(8'ha8, 32'h55555555);
        settle();
        rd(8'ha4, 32'h00000012);
        rd(8'ha8, 32'h11112222);
        wr(8'ha8, 32'h33334444);
        wr(8'ha4, 32'hc0000012);
        chk("csr_req", 32'h312, {22'h0, csr_req.req, csr_req.read, csr_req.index});
        settle();
        rd(8'ha4, 32'h40000012);
        rd(8'ha8, 32'h11112222);
        wr(8'ha4, 32'h3fffff34);
        rd(8'ha4, 32'h00000034);
        tally_and_finish();
    end
endmodule
